// file: pseq_regs.svh
/*
  Timing figures and reset levels of the push-button power sequencer.
  Assumes it is included by bare name after the package, in the debounce and sequencer design files.
*/
`ifndef PSEQ_REGS_SVH
`define PSEQ_REGS_SVH

`define CLK_HZ 20000000
`define CLK_PERIOD_NS (1000000000 / `CLK_HZ)
`define DEBOUNCE_MS 50
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * (`CLK_HZ / 1000))
`define HOLD_QUAL_NS 2000
`define HOLD_QUAL_CYCLES ((`HOLD_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUTTON_IDLE 1'b1
`define LEVEL_OFF 1'b0

`endif

// file: pseq_pkg.sv
/*
  Types of the push-button power sequencer: the one-hot power state.
  Assumes nothing of its surroundings.
*/
package pseq_pkg;
  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01,
    ST_DECIDE  = 6'h02,
    ST_WAIT_ON = 6'h04,
    ST_ON1     = 6'h08,
    ST_ON2     = 6'h10,
    ST_OFF     = 6'h20
  } power_state_e;
endpackage

// file: input_sync.sv
/*
  Three-flop synchroniser for a vector of pin levels.
  Assumes asynchronous pins; a change is passed once flops two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] q_r;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      // s1 feeds s2 only, to keep metastability out of the compare
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          s1_r[gi] <= INIT[gi];
          s2_r[gi] <= INIT[gi];
          s3_r[gi] <= INIT[gi];
          q_r[gi] <= INIT[gi];
        end
        else
        begin
          s1_r[gi] <= din[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) // R20
            q_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  assign dout = q_r;
endmodule
`default_nettype wire

// file: press_debounce.sv
/*
  Push-button debounce: falling edge delayed by DELAY cycles, rising edge passed at once.
  Assumes a synchronised active-low button level on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pseq_regs.svh"
module press_debounce #(
  parameter int DELAY = `DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic level_n,
  output logic event_out
);
  localparam int CW = $clog2(DELAY + 1);
  logic [CW-1:0] cnt_r;
  logic out_r;
  wire at_limit = (cnt_r == CW'(DELAY - 1));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      out_r <= `BUTTON_IDLE;
    end
    else if (level_n)
    begin
      // any bounce high restarts the wait
      cnt_r <= '0; // R21
      out_r <= 1'b1; // R17
    end
    else if (out_r)
    begin
      if (at_limit)
      begin
        cnt_r <= '0;
        out_r <= 1'b0; // R4
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end

  assign event_out = out_r;

  a_rise_passthru: assert property (@(posedge clk) disable iff (rst) // R17
    $rose(level_n) |=> out_r)
    else $error("button event did not follow release");
  a_fall_delayed: assert property (@(posedge clk) disable iff (rst) // R4
    $fell(out_r) |-> ($past(cnt_r) == CW'(DELAY - 1)) && !$past(level_n))
    else $error("button event fell before full debounce");
  a_count_restart: assert property (@(posedge clk) disable iff (rst) // R21
    level_n |=> (cnt_r == '0) && out_r)
    else $error("debounce count not restarted on release");
endmodule
`default_nettype wire

// file: pushbutton_power_sequencer.sv
/*
  Power on/off state machine: push-button and hold-on control of the system rail,
  converter enables in order, power-good and the debounced button event.
  Assumes asynchronous pin inputs, one 20 MHz clock and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pseq_regs.svh"
// Overview of operation
// R1: battery, standby, button falls: decide, then power-on-1, system rail enabled.
// R2: converters start in order only after the system rail reports stable.
// R3: power-good rises only when every converter has finished turning on.
// R4: button event copies the button, falling edge delayed by 50 ms.
// R5: host must raise hold-on before the button is released to stay on.
// R6: in power-on-1, hold-on high moves to power-on-2; hold-on then governs.
// R7: host drops hold-on after seeing the button event fall.
// R8: hold-on falling in power-on-2 powers off, converters in reverse order.
// R9: power-good goes low when converter shutdown begins.
// R10: on battery, system rail goes off last, then standby.
// R11: standby reached even with button held; a held level never restarts.
// R12: hold-on falling powers off even while the button stays held.
// R13: on battery, only a button falling edge leaves standby, once per press.
// R14: hold-on is ignored in standby.
// R15: button idles high; on adapter with button high, hold-on alone enables.
// R16: decide lasts one cycle: adapter to wait-for-on, battery to power-on-1.
// R17: button event rises with the button, no added delay.
// R18: hold-on low must last the qualification time; shorter pulses ignored.
// R19: with adapter power present the machine does not stay in standby.
// R20: button and hold-on are synchronised before any edge or decision.
// R21: debounce is a clock counter, restarted by any return high.
module pushbutton_power_sequencer
  import pseq_pkg::*;
#(
  parameter int NUM_CONV = 3,
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int HOLD_QUAL_CYCLES = `HOLD_QUAL_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic BUTTON_PRESS_N,
  input wire logic HOLD_ON,
  input wire logic ADAPTER_PRESENT,
  input wire logic SYS_RAIL_GOOD,
  input wire logic [NUM_CONV-1:0] CONV_READY,
  output logic SYSTEM_RAIL_EN,
  output logic [NUM_CONV-1:0] CONV_EN,
  output logic SUPPLIES_GOOD,
  output logic BUTTON_EVENT_OUT,
  output pseq_pkg::power_state_e POWER_STATE
);
  import pseq_pkg::*;

  localparam int SW = NUM_CONV + 4;
  localparam int CNTW = $clog2(NUM_CONV + 1);
  localparam int QW = $clog2(HOLD_QUAL_CYCLES + 1);

  logic [SW-1:0] sync_out;
  logic btn_s;
  logic hold_s;
  logic adapter_s;
  logic rail_good_s;
  logic [NUM_CONV-1:0] conv_ready_s;

  power_state_e state_r;
  power_state_e state_nxt;
  logic btn_prev_r;
  logic [QW-1:0] hold_low_cnt_r;
  logic [CNTW-1:0] conv_cnt_r;
  logic [NUM_CONV-1:0] conv_en_r;
  logic rail_en_r;
  logic rail_en_nxt;
  logic supplies_good_r;
  logic supplies_good_nxt;

  // the button idles high, matching its pull-up, so reset holds it released
  input_sync #(
    .WIDTH(SW),
    .INIT({{NUM_CONV{`LEVEL_OFF}}, `LEVEL_OFF, `LEVEL_OFF, `LEVEL_OFF, `BUTTON_IDLE})
  ) u_sync (
    .clk(MCLK),
    .rst(RESET),
    .din({CONV_READY, SYS_RAIL_GOOD, ADAPTER_PRESENT, HOLD_ON, BUTTON_PRESS_N}), // R20
    .dout(sync_out)
  );

  assign btn_s = sync_out[0];
  assign hold_s = sync_out[1];
  assign adapter_s = sync_out[2];
  assign rail_good_s = sync_out[3];
  assign conv_ready_s = sync_out[SW-1:4];

  press_debounce #(
    .DELAY(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk(MCLK),
    .rst(RESET),
    .level_n(btn_s),
    .event_out(BUTTON_EVENT_OUT)
  );

  // state decode
  wire st_standby = (state_r == ST_STANDBY);
  wire st_decide = (state_r == ST_DECIDE);
  wire st_wait = (state_r == ST_WAIT_ON);
  wire st_on1 = (state_r == ST_ON1);
  wire st_on2 = (state_r == ST_ON2);
  wire st_off = (state_r == ST_OFF);

  // edge only, so a button still held after power-down cannot restart
  wire btn_fall = btn_prev_r && !btn_s; // R13
  wire hold_qualified = (hold_low_cnt_r == QW'(HOLD_QUAL_CYCLES)); // R18
  wire all_on = (conv_cnt_r == CNTW'(NUM_CONV));
  wire all_off = (conv_cnt_r == '0);

  // ready of the converter just below the count going up, at the count going down; bit 0 of up_ready stands for the rail itself
  wire [NUM_CONV:0] up_ready = {conv_ready_s, 1'b1};
  wire [NUM_CONV:0] dn_ready = {1'b0, conv_ready_s};
  wire step_up = (st_on1 || st_on2) && rail_good_s && !all_on
                 && up_ready[conv_cnt_r]; // R2
  // the next converter goes off only once the last one switched off has dropped
  wire step_dn = st_off && !all_off && !dn_ready[conv_cnt_r]; // R8

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_STANDBY: // R14
      begin
        // hold-on plays no part here
        if (adapter_s) // R19
          state_nxt = ST_DECIDE;
        else if (btn_fall) // R13
          state_nxt = ST_DECIDE; // R1
      end
      ST_DECIDE:
      begin
        if (adapter_s) // R16
          state_nxt = ST_WAIT_ON;
        else
          state_nxt = ST_ON1; // R1
      end
      ST_WAIT_ON:
      begin
        if (!adapter_s)
          state_nxt = ST_STANDBY;
        else if (btn_fall || (btn_s && hold_s)) // R15
          state_nxt = ST_ON1;
      end
      ST_ON1:
      begin
        if (hold_s) // R6
          state_nxt = ST_ON2;
        else if (btn_s) // R5
          state_nxt = ST_OFF;
      end
      ST_ON2:
      begin
        // the button level is not looked at, held or not
        if (hold_qualified) // R12
          state_nxt = ST_OFF; // R8
      end
      ST_OFF:
      begin
        if (all_off && adapter_s)
          state_nxt = ST_DECIDE;
        else if (all_off && !rail_en_r && !rail_good_s) // R10
          state_nxt = ST_STANDBY; // R11
      end
      default:
        state_nxt = ST_STANDBY;
    endcase
  end

  // on adapter the rail stays up throughout; on battery it falls after the converters
  assign rail_en_nxt = adapter_s || st_on1 || st_on2 || (st_off && !all_off); // R10
  // judged on the next state so power-good drops on the cycle shutdown begins
  assign supplies_good_nxt = ((state_nxt == ST_ON1) || (state_nxt == ST_ON2))
                             && all_on && (&conv_ready_s); // R3 R9

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      state_r <= ST_STANDBY;
      btn_prev_r <= `BUTTON_IDLE;
      rail_en_r <= `LEVEL_OFF;
      supplies_good_r <= `LEVEL_OFF;
    end
    else
    begin
      state_r <= state_nxt;
      btn_prev_r <= btn_s;
      rail_en_r <= rail_en_nxt;
      supplies_good_r <= supplies_good_nxt;
    end
  end

  // hold-on low qualification, saturating
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      hold_low_cnt_r <= '0;
    else if (hold_s)
      hold_low_cnt_r <= '0; // R18
    else if (!hold_qualified)
      hold_low_cnt_r <= hold_low_cnt_r + 1'b1;
  end

  // converters are enabled as a thermometer code, lowest index first
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      conv_cnt_r <= '0;
    else if (step_up)
      conv_cnt_r <= conv_cnt_r + 1'b1;
    else if (step_dn)
      conv_cnt_r <= conv_cnt_r - 1'b1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONV; gi = gi + 1)
    begin : g_conv
      wire set_en = step_up && (conv_cnt_r == CNTW'(gi));
      wire clr_en = step_dn && (conv_cnt_r == CNTW'(gi + 1));
      always_ff @(posedge MCLK)
      begin
        if (RESET)
          conv_en_r[gi] <= `LEVEL_OFF;
        else if (set_en)
          conv_en_r[gi] <= 1'b1; // R2
        else if (clr_en)
          conv_en_r[gi] <= 1'b0; // R8
      end
    end
  endgenerate

  assign SYSTEM_RAIL_EN = rail_en_r;
  assign CONV_EN = conv_en_r;
  assign SUPPLIES_GOOD = supplies_good_r;
  assign POWER_STATE = state_r;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  sequence s_decide_then_on1;
    st_decide ##1 st_on1;
  endsequence

  sequence s_short_low;
    st_on2 && !hold_s && !hold_qualified ##1 hold_s;
  endsequence

  a_wake_on_press: assert property ( // R1
    st_standby && btn_fall && !adapter_s |=> s_decide_then_on1)
    else $error("button press did not wake through decide");
  a_rail_before_conv: assert property ( // R2
    $rose(conv_en_r[0]) |-> $past(rail_good_s) && rail_en_r)
    else $error("converter enabled before rail stable");
  a_good_all_on: assert property ( // R3
    supplies_good_r |-> (&conv_en_r) && $past(&conv_ready_s))
    else $error("power-good high before all converters on");
  a_on1_to_on2: assert property ( // R6
    st_on1 && hold_s |=> st_on2)
    else $error("hold-on high did not reach power-on-2");
  a_off_reverse: assert property ( // R8
    st_off && $past(st_off) && (conv_en_r != $past(conv_en_r))
    |-> conv_en_r == ($past(conv_en_r) >> 1))
    else $error("converters not switched off in reverse order");
  a_hold_powers_off: assert property ( // R8
    st_on2 && hold_qualified |=> st_off && !supplies_good_r)
    else $error("qualified hold-on low did not power off");
  a_good_low_off: assert property ( // R9
    st_off |-> !supplies_good_r)
    else $error("power-good still high during power-off");
  a_good_needs_on: assert property ( // R9
    supplies_good_r |-> st_on1 || st_on2)
    else $error("power-good high outside the power-on states");
  a_rail_last: assert property ( // R10
    $fell(rail_en_r) |-> (conv_en_r == '0))
    else $error("system rail dropped before converters");
  a_rail_under_conv: assert property ( // R10
    (|conv_en_r) |-> rail_en_r)
    else $error("converter enabled without the system rail");
  a_standby_hold: assert property ( // R14
    st_standby && !adapter_s && !btn_fall |=> st_standby)
    else $error("standby left without a press");
  a_wait_holds: assert property ( // R15
    st_wait && adapter_s && !btn_s && !btn_fall |=> st_wait)
    else $error("wait-on left while the button stayed held");
  a_decide_once: assert property ( // R16
    st_decide |=> ($past(adapter_s) ? st_wait : st_on1))
    else $error("decide lasted more than one cycle");
  a_short_pulse: assert property ( // R18
    s_short_low |-> st_on2)
    else $error("short hold-on pulse started power-down");
  a_adapter_leave: assert property ( // R19
    st_standby && adapter_s |=> st_decide)
    else $error("standby held with adapter present");
endmodule
`default_nettype wire

// file: host_model.sv
/*
  Far-side model: host processor on the hold-on line, plus the lag of rail and converters.
  Assumes the sequencer's clock; every output changes just after a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int NUM_CONV = 3,
  parameter int LAG = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_auto,
  input wire logic hold_force,
  input wire logic event_out,
  input wire logic rail_en,
  input wire logic [NUM_CONV-1:0] conv_en,
  output logic hold_on,
  output logic rail_good,
  output logic [NUM_CONV-1:0] conv_ready
);
  logic hold_r;
  logic event_last_r;
  logic [LAG-1:0] rail_pipe_r;
  logic [NUM_CONV-1:0] conv_pipe_r [LAG];
  // each event fall toggles: the first keeps supplies on, the next asks for shutdown
  always @(negedge clk)
  begin
    event_last_r <= event_out;
    if (rst)
      hold_r <= 1'b0;
    else if (host_auto && event_last_r && !event_out)
      hold_r <= !hold_r;
    rail_pipe_r <= {rail_pipe_r[LAG-2:0], rail_en};
    conv_pipe_r[0] <= conv_en;
    for (int i = 1; i < LAG; i++)
      conv_pipe_r[i] <= conv_pipe_r[i-1];
  end
  // manual mode lets a scenario move hold-on at moments the host would not choose
  assign hold_on = host_auto ? hold_r : hold_force;
  assign rail_good = rail_pipe_r[LAG-1];
  assign conv_ready = conv_pipe_r[LAG-1];
endmodule
`default_nettype wire

// file: tb_pushbutton_power_sequencer.sv
/*
  Testbench of the push-button power sequencer: battery press cycles, held button,
  hold-on qualification, debounce restart and adapter start.
  Assumes the host model on the hold-on, rail-good and converter-ready lines.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pushbutton_power_sequencer;
  import pseq_pkg::*;
  localparam int DEB = 20;
  localparam int QUAL = 4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic button_n = 1'b1;
  logic adapter = 1'b0;
  logic host_auto = 1'b1;
  logic hold_force = 1'b0;
  wire logic hold_on;
  wire logic rail_good;
  wire logic [2:0] conv_ready;
  wire logic rail_en;
  wire logic [2:0] conv_en;
  wire logic sup_good;
  wire logic event_out;
  power_state_e state;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  pushbutton_power_sequencer #(.NUM_CONV(3), .DEBOUNCE_CYCLES(DEB), .HOLD_QUAL_CYCLES(QUAL))
    pushbutton_power_sequencer_i (.MCLK(mclk), .RESET(rst), .BUTTON_PRESS_N(button_n),
    .HOLD_ON(hold_on), .ADAPTER_PRESENT(adapter), .SYS_RAIL_GOOD(rail_good),
    .CONV_READY(conv_ready), .SYSTEM_RAIL_EN(rail_en), .CONV_EN(conv_en),
    .SUPPLIES_GOOD(sup_good), .BUTTON_EVENT_OUT(event_out), .POWER_STATE(state));
  host_model #(.NUM_CONV(3), .LAG(3)) host_model_i (.clk(mclk), .rst(rst),
    .host_auto(host_auto), .hold_force(hold_force), .event_out(event_out),
    .rail_en(rail_en), .conv_en(conv_en), .hold_on(hold_on), .rail_good(rail_good),
    .conv_ready(conv_ready));

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_for(input power_state_e st, input int lim);
    for (int n = 0; n < lim && state !== st; n++)
      @(negedge mclk);
  endtask

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic battery_press_cycle();
    int n;
    int t0;
    logic [2:0] e;
    host_auto = 1'b1;
    @(negedge mclk);
    button_n = 1'b0;
    t0 = cyc;
    wait_for(ST_DECIDE, 10);
    @(negedge mclk);
    check(state, ST_ON1);
    for (n = 0; n < 40 && rail_good !== 1'b1; n++) @(negedge mclk);
    check(conv_en, 3'b000);
    for (n = 0; n < DEB + 20 && event_out !== 1'b0; n++) @(negedge mclk);
    check(cyc - t0 >= DEB && cyc - t0 <= DEB + 7, 1'b1);
    for (n = 0; n < 100 && sup_good !== 1'b1; n++) @(negedge mclk);
    check(conv_en, 3'b111);
    check(state, ST_ON2);
    button_n = 1'b1;
    t0 = cyc;
    for (n = 0; n < 20 && event_out !== 1'b1; n++) @(negedge mclk);
    check(cyc - t0 <= 7, 1'b1);
    check(state, ST_ON2);
    button_n = 1'b0;
    wait_for(ST_OFF, DEB + QUAL + 40);
    check(sup_good, 1'b0);
    for (int i = 2; i >= 0; i--)
    begin
      e = 3'((1 << i) - 1);
      for (n = 0; n < 40 && conv_en !== e; n++) @(negedge mclk);
      check(conv_en, e);
    end
    check(rail_en, 1'b1);
    wait_for(ST_STANDBY, 60);
    check(rail_en, 1'b0);
    repeat (30) @(negedge mclk);
    check(state, ST_STANDBY);
    button_n = 1'b1;
    repeat (10) @(negedge mclk);
  endtask

  task automatic held_button_hold_off();
    int n;
    host_auto = 1'b0;
    button_n = 1'b0;
    hold_force = 1'b1;
    wait_for(ST_ON2, 60);
    for (n = 0; n < 100 && sup_good !== 1'b1; n++) @(negedge mclk);
    hold_force = 1'b0;
    repeat (QUAL - 2) @(negedge mclk);
    hold_force = 1'b1;
    repeat (20) @(negedge mclk);
    check({state, sup_good}, {ST_ON2, 1'b1});
    hold_force = 1'b0;
    wait_for(ST_OFF, 30);
    check(state, ST_OFF);
    wait_for(ST_STANDBY, 80);
    hold_force = 1'b1;
    repeat (20) @(negedge mclk);
    check({state, rail_en}, {ST_STANDBY, 1'b0});
    hold_force = 1'b0;
    button_n = 1'b1;
    repeat (10) @(negedge mclk);
    check(state, ST_STANDBY);
  endtask

  task automatic debounce_restart();
    logic low_seen;
    low_seen = 1'b0;
    for (int n = 0; n < 60; n++)
    begin
      @(negedge mclk);
      button_n = !(n < 10 || (n >= 13 && n < 23));
      if (event_out === 1'b0)
        low_seen = 1'b1;
    end
    check(low_seen, 1'b0);
    wait_for(ST_STANDBY, 300);
    check(state, ST_STANDBY);
  endtask

  task automatic adapter_start();
    int n;
    host_auto = 1'b0;
    adapter = 1'b1;
    wait_for(ST_WAIT_ON, 20);
    repeat (10) @(negedge mclk);
    check(state, ST_WAIT_ON);
    hold_force = 1'b1;
    wait_for(ST_ON2, 30);
    for (n = 0; n < 100 && sup_good !== 1'b1; n++) @(negedge mclk);
    check({state, conv_en}, {ST_ON2, 3'b111});
    hold_force = 1'b0;
    wait_for(ST_OFF, 30);
    wait_for(ST_WAIT_ON, 100);
    check({state, rail_en}, {ST_WAIT_ON, 1'b1});
    button_n = 1'b0;
    wait_for(ST_ON1, 20);
    check(state, ST_ON1);
    hold_force = 1'b1;
    wait_for(ST_ON2, 20);
    hold_force = 1'b0;
    wait_for(ST_WAIT_ON, 120);
    hold_force = 1'b1;
    repeat (20) @(negedge mclk);
    check(state, ST_WAIT_ON);
    button_n = 1'b1;
    wait_for(ST_ON2, 20);
    check(state, ST_ON2);
    hold_force = 1'b0;
    wait_for(ST_WAIT_ON, 120);
    adapter = 1'b0;
    wait_for(ST_STANDBY, 30);
    check({state, rail_en}, {ST_STANDBY, 1'b0});
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    check(state, ST_STANDBY);
    check({rail_en, conv_en, sup_good, event_out}, 6'h01);
    battery_press_cycle();
    held_button_hold_off();
    debounce_restart();
    adapter_start();
    final_report();
  end
endmodule
`default_nettype wire
